// ===== mcfr_pkg.sv
package mcfr_pkg;
  // Operating modes of the instrument.
  typedef enum logic [2:0] {
    MCFR_MODE_PROG = 3'h0,
    MCFR_MODE_COMBI = 3'h1,
    MCFR_MODE_SEQ = 3'h2,
    MCFR_MODE_SPLAY = 3'h3,
    MCFR_MODE_SAMPLE = 3'h4
  } mcfr_mode_t;

  // Timbre or track status.
  typedef enum logic [2:0] {
    MCFR_ST_OFF = 3'h0,
    MCFR_ST_INT = 3'h1,
    MCFR_ST_EXT = 3'h2,
    MCFR_ST_EX2 = 3'h3,
    MCFR_ST_BOTH = 3'h4
  } mcfr_status_t;

  // Note receive filter settings.
  typedef enum logic [1:0] {
    MCFR_NOTE_ALL = 2'h0,
    MCFR_NOTE_EVEN = 2'h1,
    MCFR_NOTE_ODD = 2'h2
  } mcfr_note_t;

  // Sync clock source settings.
  typedef enum logic [1:0] {
    MCFR_CLK_INT = 2'h0,
    MCFR_CLK_EXT_SER = 2'h1,
    MCFR_CLK_EXT_USB = 2'h2
  } mcfr_clksrc_t;

  // Message sources.
  typedef enum logic [1:0] {
    MCFR_SRC_KEYS = 2'h0,
    MCFR_SRC_SERIAL = 2'h1,
    MCFR_SRC_USB = 2'h2,
    MCFR_SRC_SEQ = 2'h3
  } mcfr_src_t;

  // Message classes, decoded upstream.
  typedef enum logic [3:0] {
    MCFR_MSG_NOTE = 4'h0,
    MCFR_MSG_PCHG = 4'h1,
    MCFR_MSG_CTRL = 4'h2,
    MCFR_MSG_FXSW = 4'h3,
    MCFR_MSG_FXCTL = 4'h4,
    MCFR_MSG_SYSEX = 4'h5,
    MCFR_MSG_CLOCK = 4'h6,
    MCFR_MSG_SPP = 4'h7,
    MCFR_MSG_SSEL = 4'h8,
    MCFR_MSG_START = 4'h9,
    MCFR_MSG_CONT = 4'ha,
    MCFR_MSG_STOP = 4'hb,
    MCFR_MSG_OTHER = 4'hc
  } mcfr_msg_t;

  localparam int MCFR_NPART = 16;
  localparam int MCFR_NFX = 8;
  localparam logic [3:0] MCFR_GCH_RST = 4'h0;
  localparam logic [4:0] MCFR_FXCH_GLOBAL = 5'h10;

  // One routed message word.
  typedef struct packed {
    mcfr_msg_t kind;
    logic [3:0] chan;
    logic [6:0] data1;
    logic [6:0] data2;
    logic [3:0] part;
    logic convert;
  } mcfr_word_t;
endpackage : mcfr_pkg

// ===== mcfr_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface mcfr_stream_if;
  import mcfr_pkg::*;
  logic valid;
  logic ready;
  mcfr_word_t word;
  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface : mcfr_stream_if
`default_nettype wire

// ===== mcfr_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module mcfr_buf2 (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Streams.
  mcfr_stream_if.snk inS,
  mcfr_stream_if.src outS
);
  import mcfr_pkg::*;

  typedef struct packed {
    mcfr_word_t [1:0] slot;
    logic [1:0] count;
  } mcfr_buf_t;

  mcfr_buf_t st_ff;
  mcfr_buf_t nxt_st;
  logic push;
  logic pop;

  // Two entries let the upstream keep flowing for one stalled cycle.
  assign inS.ready = (st_ff.count != 2'h2);
  assign outS.valid = (st_ff.count != 2'h0);
  assign outS.word = st_ff.slot[0];
  assign push = inS.valid && inS.ready;
  assign pop = outS.valid && outS.ready;

  // Shift-out queue, head always in slot zero.
  always_comb begin
    nxt_st = st_ff;
    if (pop) begin
      nxt_st.slot[0] = st_ff.slot[1];
    end
    if (push) begin
      if (st_ff.count == 2'h0 || (pop && st_ff.count == 2'h1)) begin
        nxt_st.slot[0] = inS.word;
      end else begin
        nxt_st.slot[pop ? 0 : 1] = inS.word;
      end
    end
    nxt_st.count = st_ff.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : mcfr_buf2
`default_nettype wire

// ===== mcfr_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module mcfr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Data.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mcfr_sync_t;

  mcfr_sync_t st_ff;
  mcfr_sync_t nxt_st;

  // The first stage feeds only the second, to contain metastability.
  always_comb begin
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.s2;
endmodule : mcfr_sync2
`default_nettype wire

// ===== mcfr_router.sv
`timescale 1ns/10ps
`default_nettype none
module mcfr_router (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Settings from the panel logic.
  input wire logic [3:0] globalChanIn,
  input wire logic globalChanWr,
  input wire mcfr_pkg::mcfr_mode_t opMode,
  input wire logic localControlOn,
  input wire mcfr_pkg::mcfr_note_t noteFilter,
  input wire logic convertAfterLink,
  input wire mcfr_pkg::mcfr_clksrc_t clockSource,
  input wire logic rtReceiveIn,
  input wire logic rtReceiveWr,
  input wire logic progChangeEn,
  input wire logic combiChangeEn,
  input wire logic [3:0] selTrack,
  // Per-part channel and status, per-effect control channel.
  input wire logic [63:0] partChan,
  input wire logic [47:0] partStatus,
  input wire logic [39:0] effectControlChannel,
  // Incoming message, one word with handshake.
  input wire logic inValid,
  output logic inReady,
  input wire mcfr_pkg::mcfr_src_t inSrc,
  input wire mcfr_pkg::mcfr_word_t inWord,
  // Local program or setup switch request.
  input wire logic localPchg,
  input wire logic [6:0] localPchgNum,
  // Raw timing clock ticks from the pins, and the internal tick.
  input wire logic serialTickPin,
  input wire logic usbTickPin,
  input wire logic internalTick,
  // Tone generator stream.
  output logic toneValid,
  input wire logic toneReady,
  output mcfr_pkg::mcfr_word_t toneWord,
  // Outgoing MIDI word.
  output logic txValid,
  output mcfr_pkg::mcfr_word_t txWord,
  // Recorder word.
  output logic recValid,
  output mcfr_pkg::mcfr_word_t recWord,
  // Setup and sync outcomes.
  output logic setupSwitch,
  output logic [6:0] setupNum,
  output logic seqTick,
  output logic songCmdValid,
  output mcfr_pkg::mcfr_msg_t songCmd,
  // Settings readback.
  output logic [3:0] globalChan,
  output logic rtReceive
);
  import mcfr_pkg::*;

  // Fan-out walker states for multi-channel sends.
  typedef enum logic [1:0] {
    MCFR_IDLE = 2'h0,
    MCFR_FAN = 2'h1
  } mcfr_fsm_t;

  typedef struct packed {
    logic [3:0] gch;
    logic rtRx;
    mcfr_fsm_t fsm;
    logic [4:0] idx;
    mcfr_word_t fanWord;
    logic txV;
    mcfr_word_t txW;
    logic recV;
    mcfr_word_t recW;
    logic setupV;
    logic [6:0] setupN;
    logic tick;
    logic songV;
    mcfr_msg_t songC;
  } mcfr_state_t;

  mcfr_state_t st_ff;
  mcfr_state_t nxt_st;
  logic serTick;
  logic usbTick;
  logic serTickD_ff;
  logic usbTickD_ff;
  logic toneInValid;
  logic toneInReady;
  mcfr_word_t toneIn;

  mcfr_stream_if toneA();
  mcfr_stream_if toneB();

  // Per-part lookups used in several places.
  function automatic logic [3:0] chanOf(input logic [63:0] v,
                                        input logic [4:0] i);
    chanOf = v[i[3:0]*4 +: 4];
  endfunction : chanOf

  function automatic mcfr_status_t statOf(input logic [47:0] v,
                                          input logic [4:0] i);
    statOf = mcfr_status_t'(v[i[3:0]*3 +: 3]);
  endfunction : statOf

  function automatic logic goesOut(input mcfr_status_t s);
    goesOut = (s == MCFR_ST_EXT) || (s == MCFR_ST_EX2);
  endfunction : goesOut

  // Pin ticks are resynchronised before edge detection.
  mcfr_sync2 #(.W(2)) tickSync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din({serialTickPin, usbTickPin}),
    .dout({serTick, usbTick})
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serTickD_ff <= 1'b0;
      usbTickD_ff <= 1'b0;
    end else begin
      serTickD_ff <= serTick;
      usbTickD_ff <= usbTick;
    end
  end

  // The buffer absorbs a stall from the tone generator without loss.
  assign toneA.valid = toneInValid;
  assign toneA.word = toneIn;
  assign toneInReady = toneA.ready;
  assign toneValid = toneB.valid;
  assign toneWord = toneB.word;
  assign toneB.ready = toneReady;

  mcfr_buf2 toneBuf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inS(toneA),
    .outS(toneB)
  );

  // Inputs are held off while fanning out or while the buffer is full.
  assign inReady = (st_ff.fsm == MCFR_IDLE) && toneInReady;

  // Routing decisions for one incoming word.
  always_comb begin
    logic isLocal;
    logic isExt;
    logic onG;
    logic hit;
    logic sound;
    logic take;
    logic extClk;
    logic [4:0] i;
    mcfr_word_t w;
    extClk = 1'b0;
    i = 5'h0;
    isLocal = (inSrc == MCFR_SRC_KEYS);
    isExt = (inSrc == MCFR_SRC_SERIAL) || (inSrc == MCFR_SRC_USB);
    onG = (inWord.chan == st_ff.gch);
    hit = 1'b0;
    sound = 1'b0;
    take = inValid && inReady;
    w = inWord;
    nxt_st = st_ff;
    nxt_st.txV = 1'b0;
    nxt_st.recV = 1'b0;
    nxt_st.setupV = 1'b0;
    nxt_st.songV = 1'b0;
    toneInValid = 1'b0;
    toneIn = inWord;
    // Global channel kept as the raw nibble; zero is channel 1.
    if (globalChanWr) begin
      nxt_st.gch = globalChanIn;
    end
    if (rtReceiveWr && clockSource != MCFR_CLK_INT) begin
      nxt_st.rtRx = rtReceiveIn;
    end
    // Song play ignores the source and always follows the own clock.
    extClk = (clockSource != MCFR_CLK_INT) && (opMode != MCFR_MODE_SPLAY);
    if (!extClk) begin
      nxt_st.tick = internalTick;
    end else if (clockSource == MCFR_CLK_EXT_SER) begin
      nxt_st.tick = serTick && !serTickD_ff;
    end else begin
      nxt_st.tick = usbTick && !usbTickD_ff;
    end
    // Does the channel match an accepting part?
    for (int k = 0; k < MCFR_NPART; k++) begin
      if (chanOf(partChan, 5'(k)) == inWord.chan &&
          statOf(partStatus, 5'(k)) != MCFR_ST_OFF) begin
        hit = 1'b1;
      end
    end
    if (take && st_ff.fsm == MCFR_IDLE) begin
      case (inWord.kind)
        MCFR_MSG_NOTE, MCFR_MSG_CTRL: begin
          // Accepting channel depends on mode.
          if (isExt) begin
            sound = (opMode == MCFR_MODE_PROG ||
                     opMode == MCFR_MODE_SAMPLE) ? onG : hit;
          end else begin
            sound = localControlOn;
          end
          if (inWord.kind == MCFR_MSG_NOTE) begin
            if (noteFilter == MCFR_NOTE_EVEN && inWord.data1[0]) begin
              sound = 1'b0;
            end
            if (noteFilter == MCFR_NOTE_ODD && !inWord.data1[0]) begin
              sound = 1'b0;
            end
          end
          // Post-link converts whatever sounds; local always does.
          toneIn.convert = isLocal || convertAfterLink;
          toneInValid = sound;
          if (isLocal) begin
            w.convert = !convertAfterLink;
            w.chan = st_ff.gch;
            if (opMode == MCFR_MODE_SEQ) begin
              w.chan = chanOf(partChan, {1'b0, selTrack});
              nxt_st.txV = goesOut(statOf(partStatus, {1'b0, selTrack})) ||
                statOf(partStatus, {1'b0, selTrack}) == MCFR_ST_BOTH;
              nxt_st.recV = 1'b1;
            end else begin
              nxt_st.txV = 1'b1;
              nxt_st.recV = (opMode != MCFR_MODE_SAMPLE);
            end
            nxt_st.txW = w;
            nxt_st.recW = w;
            if (opMode == MCFR_MODE_COMBI) begin
              nxt_st.fanWord = w;
              nxt_st.idx = 5'h0;
              nxt_st.fsm = MCFR_FAN;
            end
          end else if (inSrc == MCFR_SRC_SEQ) begin
            w.convert = 1'b0;
            nxt_st.txV = 1'b1;
            nxt_st.txW = w;
          end
        end
        MCFR_MSG_FXSW: begin
          toneInValid = onG;
        end
        MCFR_MSG_FXCTL: begin
          i = {2'h0, inWord.part[2:0]};
          if (opMode == MCFR_MODE_PROG || opMode == MCFR_MODE_SAMPLE ||
              effectControlChannel[i*5 +: 5] == MCFR_FXCH_GLOBAL) begin
            toneInValid = onG;
          end else begin
            toneInValid =
              (effectControlChannel[i*5 +: 5] == {1'b0, inWord.chan});
          end
        end
        MCFR_MSG_SYSEX: begin
          toneInValid = onG;
        end
        MCFR_MSG_PCHG: begin
          if (progChangeEn && isExt) begin
            case (opMode)
              MCFR_MODE_PROG: begin
                toneInValid = onG;
              end
              MCFR_MODE_COMBI: begin
                if (onG && combiChangeEn) begin
                  nxt_st.setupV = 1'b1;
                  nxt_st.setupN = inWord.data1;
                end else begin
                  toneInValid = hit;
                end
              end
              MCFR_MODE_SEQ: begin
                toneInValid = 1'b0;
                for (int k = 0; k < MCFR_NPART; k++) begin
                  if (chanOf(partChan, 5'(k)) == inWord.chan &&
                      (statOf(partStatus, 5'(k)) == MCFR_ST_INT ||
                       statOf(partStatus, 5'(k)) == MCFR_ST_BOTH)) begin
                    toneInValid = 1'b1;
                  end
                end
              end
              default: begin
                toneInValid = 1'b0;
              end
            endcase
          end else if (progChangeEn && inSrc == MCFR_SRC_SEQ) begin
            // Song playback forwards changes of outward tracks.
            nxt_st.txV = goesOut(statOf(partStatus, {1'b0, inWord.part})) ||
              statOf(partStatus, {1'b0, inWord.part}) == MCFR_ST_BOTH;
            nxt_st.txW = inWord;
          end
        end
        MCFR_MSG_SPP, MCFR_MSG_START, MCFR_MSG_CONT, MCFR_MSG_STOP,
        MCFR_MSG_SSEL: begin
          // Song commands come only from the selected external port.
          if (extClk && ((clockSource == MCFR_CLK_EXT_SER &&
              inSrc == MCFR_SRC_SERIAL) || (clockSource == MCFR_CLK_EXT_USB &&
              inSrc == MCFR_SRC_USB))) begin
            nxt_st.songV = st_ff.rtRx || inWord.kind == MCFR_MSG_SSEL;
            nxt_st.songC = inWord.kind;
          end
        end
        default: begin
          toneInValid = 1'b0;
        end
      endcase
    end
    // Local program switch, sent on the global channel; in combi mode the fan walker adds the copies.
    if (st_ff.fsm == MCFR_IDLE && localPchg && progChangeEn &&
        !(take && isLocal)) begin
      w = '0;
      w.kind = MCFR_MSG_PCHG;
      w.chan = st_ff.gch;
      w.data1 = localPchgNum;
      nxt_st.txV = 1'b1;
      nxt_st.txW = w;
      if (opMode == MCFR_MODE_COMBI) begin
        nxt_st.fanWord = w;
        nxt_st.idx = 5'h0;
        nxt_st.fsm = MCFR_FAN;
      end
    end
    // Walk the timbres, one extra copy per outward timbre.
    if (st_ff.fsm == MCFR_FAN) begin
      i = st_ff.idx;
      if (goesOut(statOf(partStatus, i))) begin
        w = st_ff.fanWord;
        w.chan = chanOf(partChan, i);
        nxt_st.txV = 1'b1;
        nxt_st.txW = w;
      end
      nxt_st.idx = st_ff.idx + 5'h1;
      if (st_ff.idx == 5'(MCFR_NPART - 1)) begin
        nxt_st.fsm = MCFR_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Registered outputs.
  assign txValid = st_ff.txV;
  assign txWord = st_ff.txW;
  assign recValid = st_ff.recV;
  assign recWord = st_ff.recW;
  assign setupSwitch = st_ff.setupV;
  assign setupNum = st_ff.setupN;
  assign seqTick = st_ff.tick;
  assign songCmdValid = st_ff.songV;
  assign songCmd = st_ff.songC;
  assign globalChan = st_ff.gch;
  assign rtReceive = st_ff.rtRx;
endmodule : mcfr_router
`default_nettype wire

// ===== mcfr_tone_sink.sv
`timescale 1ns/10ps
`default_nettype none
// Tone generator stand-in that takes words unless the bench stalls it.
module mcfr_tone_sink (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Tone stream.
  input wire logic toneValid,
  output logic toneReady,
  // Bench control and tally.
  input wire logic stall,
  output int wordCount
);
  import mcfr_pkg::*;
  // A stalled generator refuses words, so the buffer has to hold them.
  assign toneReady = !stall;
  // Count accepted words so that a lost or doubled word shows up.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wordCount <= 0;
    end else if (toneValid && toneReady) begin
      wordCount <= wordCount + 1;
    end
  end
endmodule : mcfr_tone_sink
`default_nettype wire

// ===== mcfr_router_checker.sv
`timescale 1ns/10ps
`default_nettype none
module mcfr_router_checker (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Settings.
  input wire logic [3:0] globalChanIn,
  input wire logic globalChanWr,
  input wire mcfr_pkg::mcfr_mode_t opMode,
  input wire logic localControlOn,
  input wire mcfr_pkg::mcfr_note_t noteFilter,
  input wire mcfr_pkg::mcfr_clksrc_t clockSource,
  input wire logic rtReceiveIn,
  input wire logic rtReceiveWr,
  input wire logic progChangeEn,
  // Incoming words and ticks.
  input wire logic inValid,
  input wire logic inReady,
  input wire mcfr_pkg::mcfr_src_t inSrc,
  input wire mcfr_pkg::mcfr_word_t inWord,
  input wire logic internalTick,
  // Outputs.
  input wire logic toneValid,
  input wire mcfr_pkg::mcfr_word_t toneWord,
  input wire logic txValid,
  input wire mcfr_pkg::mcfr_word_t txWord,
  input wire logic recValid,
  input wire logic setupSwitch,
  input wire logic seqTick,
  input wire logic songCmdValid,
  input wire mcfr_pkg::mcfr_msg_t songCmd,
  input wire logic [3:0] globalChan,
  input wire logic rtReceive
);
  import mcfr_pkg::*;
  logic take;
  logic extSer;
  // A word counts only on a handshake edge.
  assign take = inValid && inReady;
  // Song play ignores the external clock, so serial song words are exempt.
  assign extSer = clockSource == MCFR_CLK_EXT_SER
                  && opMode != MCFR_MODE_SPLAY;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chan_write_a: assert property (
    globalChanWr |=> globalChan == $past(globalChanIn))
    else $error("global channel not written");
  rt_lock_a: assert property (
    clockSource == MCFR_CLK_INT |=> $stable(rtReceive))
    else $error("realtime setting changed on internal clock");
  rt_write_a: assert property (
    rtReceiveWr && clockSource != MCFR_CLK_INT
      |=> rtReceive == $past(rtReceiveIn))
    else $error("realtime setting not written");
  song_drop_a: assert property (
    take && inSrc == MCFR_SRC_SERIAL && extSer && !rtReceive
      && inWord.kind inside {MCFR_MSG_SPP, MCFR_MSG_START,
      MCFR_MSG_CONT, MCFR_MSG_STOP} |=> !songCmdValid)
    else $error("song command passed with reception off");
  song_select_a: assert property (
    take && inSrc == MCFR_SRC_SERIAL && extSer
      && inWord.kind == MCFR_MSG_SSEL
      |=> songCmdValid && songCmd == MCFR_MSG_SSEL)
    else $error("song select not passed");
  int_tick_a: assert property (
    internalTick && (clockSource == MCFR_CLK_INT
      || opMode == MCFR_MODE_SPLAY) |=> seqTick)
    else $error("internal tick not followed");
  pchg_off_a: assert property (
    take && !progChangeEn && inWord.kind == MCFR_MSG_PCHG
      |=> !setupSwitch)
    else $error("program change acted on while disabled");
  keys_note_a: assert property (
    take && inSrc == MCFR_SRC_KEYS && inWord.kind == MCFR_MSG_NOTE
      && opMode == MCFR_MODE_PROG && localControlOn && !toneValid
      && noteFilter == MCFR_NOTE_ALL
      |=> txValid && recValid && toneValid && toneWord.convert
      && txWord.chan == $past(globalChan))
    else $error("keyboard note not routed");
  odd_filter_a: assert property (
    take && inSrc == MCFR_SRC_SERIAL && inWord.kind == MCFR_MSG_NOTE
      && noteFilter == MCFR_NOTE_EVEN && inWord.data1[0] && !toneValid
      |=> !toneValid)
    else $error("odd note sounded with even filter");
  fan_hold_a: assert property (
    take && inSrc == MCFR_SRC_KEYS && inWord.kind == MCFR_MSG_NOTE
      && opMode == MCFR_MODE_COMBI |=> !inReady [*8])
    else $error("input taken during timbre fan out");
  // Main traffic kinds seen at least once.
  cover property (take && opMode == MCFR_MODE_COMBI);
  cover property (songCmdValid);
  cover property (setupSwitch);
endmodule : mcfr_router_checker
bind mcfr_router mcfr_router_checker chk (.*);
`default_nettype wire

// ===== mcfr_router_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
  num_errors++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module mcfr_router_tb;
  import mcfr_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst, globalChanWr, localControlOn, convertAfterLink, stall;
  logic rtReceiveIn, rtReceiveWr, progChangeEn, combiChangeEn;
  logic inValid, inReady, localPchg, serialTickPin, usbTickPin;
  logic internalTick, toneValid, toneReady, txValid, recValid;
  logic setupSwitch, seqTick, songCmdValid, rtReceive;
  logic [3:0] globalChanIn, selTrack, globalChan, g;
  logic [6:0] localPchgNum, setupNum, nt;
  logic [63:0] partChan;
  logic [47:0] partStatus, st;
  logic [39:0] effectControlChannel;
  logic [4:0] seen;
  mcfr_mode_t opMode;
  mcfr_note_t noteFilter;
  mcfr_clksrc_t clockSource;
  mcfr_src_t inSrc;
  mcfr_msg_t songCmd;
  mcfr_word_t inWord, toneWord, txWord, recWord, txW, toneW, recW;
  int num_errors = 0, cmp_count = 0, cyc = 0, seed = 13, wordCount, n;
  mcfr_router DUT (.*);
  mcfr_tone_sink TG (.*);
  // Free running 40 MHz clock.
  always #12.5 clk_sys = ~clk_sys;
  // Hang guard, far above the few hundred cycles the run needs.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      complete_run();
    end
  end
  task complete_run;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Offer one word, hold it until taken, then snapshot the answers.
  task automatic send(mcfr_src_t s, mcfr_msg_t k, logic [3:0] c,
                      logic [6:0] d);
    int w = 0;
    @(posedge clk_sys);
    inSrc <= s;
    inWord <= '{kind: k, chan: c, data1: d, data2: 7'h40, default: '0};
    inValid <= 1'b1;
    @(negedge clk_sys);
    while (inReady !== 1'b1 && w < 40) begin
      w++;
      @(negedge clk_sys);
    end
    `CHK(inReady, 1'b1)
    @(posedge clk_sys);
    inValid <= 1'b0;
    @(negedge clk_sys);
    seen = {txValid, recValid, toneValid, setupSwitch, songCmdValid};
    txW = txWord;
    toneW = toneWord;
    recW = recWord;
  endtask : send
  // Raise one tick source and count sequencer ticks over six cycles.
  task automatic tick(int w);
    @(posedge clk_sys);
    internalTick <= w == 0;
    serialTickPin <= w == 1;
    usbTickPin <= w == 2;
    @(posedge clk_sys);
    internalTick <= 1'b0;
    n = 0;
    repeat (6) begin
      @(negedge clk_sys);
      n += seqTick;
    end
    @(posedge clk_sys);
    serialTickPin <= 1'b0;
    usbTickPin <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : tick
  // The filter decides sounding only; EVEN wants bit 0 clear.
  function automatic logic sounds(mcfr_note_t f, logic [6:0] k);
    return f == MCFR_NOTE_ALL || (f == MCFR_NOTE_EVEN) == !k[0];
  endfunction : sounds
  // Global channel plus every timbre that goes outside.
  function automatic int fanExp(logic [47:0] s);
    int c = 1;
    for (int k = 0; k < 16; k++) begin
      c += s[3*k+:3] inside {MCFR_ST_EXT, MCFR_ST_EX2};
    end
    return c;
  endfunction : fanExp
  // Song play and internal source follow only the internal tick.
  function automatic int tickExp(int w);
    if (opMode == MCFR_MODE_SPLAY || clockSource == MCFR_CLK_INT) begin
      return w == 0;
    end
    return w == int'(clockSource);
  endfunction : tickExp
  // Main sequence: reset, then settings, routing, programs and sync.
  initial begin
    nrst = 1'b0;
    {globalChanWr, rtReceiveIn, rtReceiveWr, inValid, localPchg} = '0;
    {serialTickPin, usbTickPin, internalTick, stall} = '0;
    {localControlOn, progChangeEn, combiChangeEn} = 3'h7;
    {convertAfterLink, globalChanIn, selTrack, localPchgNum} = '0;
    {opMode, noteFilter, clockSource, inSrc, inWord} = '0;
    partChan = {$random(seed), $random(seed)};
    partStatus = '0;
    effectControlChannel = {8{MCFR_FXCH_GLOBAL}};
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    `CHK({globalChan, rtReceive}, 5'h00)
    for (int i = 0; i < 2; i++) begin
      g = i == 0 ? 4'hf : 4'($random(seed));
      @(posedge clk_sys);
      globalChanIn <= g;
      globalChanWr <= 1'b1;
      @(posedge clk_sys);
      globalChanWr <= 1'b0;
      @(negedge clk_sys);
      `CHK(globalChan, g)
    end
    for (int c = 0; c < 2; c++) begin
      @(posedge clk_sys);
      convertAfterLink <= c[0];
      nt = 7'($random(seed));
      send(MCFR_SRC_KEYS, MCFR_MSG_NOTE, g, nt);
      `CHK({seen[4:2], txW.chan}, {3'h7, g})
      `CHK(txW.convert, !c[0])
      `CHK(recW.convert, !c[0])
      `CHK(toneW.convert, 1'b1)
      send(MCFR_SRC_SERIAL, MCFR_MSG_NOTE, g, nt);
      `CHK({seen[2], toneW.convert}, {1'b1, c[0]})
    end
    send(MCFR_SRC_SERIAL, MCFR_MSG_NOTE, g + 4'h1, nt);
    `CHK(seen[2], 1'b0)
    for (int f = 0; f < 6; f++) begin
      @(posedge clk_sys);
      noteFilter <= mcfr_note_t'(f / 2);
      nt = {6'($random(seed)), f[0]};
      send(MCFR_SRC_SERIAL, MCFR_MSG_NOTE, g, nt);
      `CHK(seen[2], sounds(mcfr_note_t'(f / 2), nt))
      if (seen[2] === 1'b1) `CHK(toneW.data1, nt)
    end
    @(posedge clk_sys);
    localControlOn <= 1'b0;
    noteFilter <= MCFR_NOTE_ALL;
    send(MCFR_SRC_KEYS, MCFR_MSG_NOTE, g, nt);
    `CHK(seen[4:2], 3'h6)
    send(MCFR_SRC_SERIAL, MCFR_MSG_NOTE, g, nt);
    `CHK(seen[2], 1'b1)
    // Effect switch, effect control and exclusive words, on and off global.
    for (int x = 0; x < 6; x++) begin
      send(MCFR_SRC_USB, mcfr_msg_t'(3 + x / 2), g + 4'(x % 2), nt);
      `CHK(seen[2], x % 2 == 0)
    end
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_sys);
      localControlOn <= 1'b1;
      progChangeEn <= e[0];
      localPchgNum <= 7'($random(seed));
      localPchg <= 1'b1;
      @(posedge clk_sys);
      localPchg <= 1'b0;
      @(negedge clk_sys);
      `CHK(txValid, e[0])
      if (e == 1) `CHK({txWord.kind, txWord.chan}, {MCFR_MSG_PCHG, g})
    end
    for (int s = 0; s < 3; s++) begin
      @(posedge clk_sys);
      opMode <= MCFR_MODE_COMBI;
      progChangeEn <= s != 2;
      combiChangeEn <= s != 1;
      nt = 7'($random(seed));
      send(MCFR_SRC_SERIAL, MCFR_MSG_PCHG, g, nt);
      `CHK(seen[1], s == 0)
      if (s == 0) `CHK(setupNum, nt)
    end
    for (int k = 0; k < 16; k++) begin
      st[3*k+:3] = 3'($unsigned($random(seed)) % 5);
    end
    @(posedge clk_sys);
    partStatus <= st;
    {progChangeEn, combiChangeEn} <= 2'h3;
    send(MCFR_SRC_KEYS, MCFR_MSG_NOTE, g, nt);
    n = seen[4];
    repeat (18) begin
      @(negedge clk_sys);
      n += txValid;
    end
    `CHK(n, fanExp(st))
    @(posedge clk_sys);
    opMode <= MCFR_MODE_SEQ;
    selTrack <= 4'($random(seed));
    send(MCFR_SRC_KEYS, MCFR_MSG_NOTE, g, nt);
    `CHK(seen[4], st[3*selTrack+:3] inside {MCFR_ST_EXT, MCFR_ST_EX2,
      MCFR_ST_BOTH})
    if (seen[4] === 1'b1) `CHK(txW.chan, partChan[4*selTrack+:4])
    @(posedge clk_sys);
    opMode <= MCFR_MODE_PROG;
    clockSource <= MCFR_CLK_EXT_SER;
    for (int r = 0; r < 3; r++) begin
      @(posedge clk_sys);
      clockSource <= r == 2 ? MCFR_CLK_INT : MCFR_CLK_EXT_SER;
      rtReceiveIn <= r == 1;
      rtReceiveWr <= 1'b1;
      @(posedge clk_sys);
      rtReceiveWr <= 1'b0;
      @(negedge clk_sys);
      `CHK(rtReceive, r != 0)
      for (int m = 7; m < 12 && r < 2; m++) begin
        send(MCFR_SRC_SERIAL, mcfr_msg_t'(m), g, 7'h00);
        `CHK(seen[0], r == 1 || m == 8)
      end
    end
    for (int cs = 0; cs < 4; cs++) begin
      @(posedge clk_sys);
      clockSource <= mcfr_clksrc_t'(cs == 3 ? 1 : cs);
      opMode <= cs == 3 ? MCFR_MODE_SPLAY : MCFR_MODE_PROG;
      for (int w = 0; w < 3; w++) begin
        tick(w);
        `CHK(n, tickExp(w))
      end
    end
    @(posedge clk_sys);
    opMode <= MCFR_MODE_PROG;
    stall <= 1'b1;
    n = wordCount;
    send(MCFR_SRC_KEYS, MCFR_MSG_NOTE, g, nt);
    send(MCFR_SRC_KEYS, MCFR_MSG_NOTE, g, nt + 7'h1);
    @(negedge clk_sys);
    `CHK({inReady, toneWord.data1}, {1'b0, nt})
    @(posedge clk_sys);
    stall <= 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK({toneValid, wordCount}, {1'b0, n + 2})
    complete_run();
  end
endmodule : mcfr_router_tb
`default_nettype wire
